// ===== logic/async_serial_receiver_recovery.sv
// Receive recovery, flags, standby wake-up and request gating of the serial receiver.
`timescale 1ns/1ps
module async_serial_receiver_recovery
   import receiver_recovery_pkg::*;
#(
   parameter int unsigned CLKS_PER_TICK = 1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic serial_input_pin_i,
   input wire logic dma_read_i,
   output logic [8:0] dma_data_o,
   output logic char_done_o,
   output logic rx_irq_o,
   output logic err_irq_o,
   output logic dma_req_o
);
   rx_state_type state;
   logic [15:0] div_cnt;
   logic tick;
   logic rxd;
   logic [2:0] hist;
   logic [3:0] phase;
   logic [1:0] samp;
   logic [3:0] bit_idx;
   logic [8:0] shift;
   logic par_acc;
   logic frame_noise;
   logic vote_level;
   logic vote_noise;
   logic [3:0] idle_tick;
   logic [3:0] idle_bits;
   logic [3:0] next_idle_tick;
   logic [3:0] next_idle_bits;
   logic [12:0] ctrl;
   logic prev_wake_sel;
   logic ack;
   logic armed;
   logic receive_full_flag;
   logic line_quiet_flag;
   logic overrun_flag;
   logic noise_flag;
   logic framing_error_flag;
   logic parity_error_flag;
   logic break_seen_flag;
   logic [8:0] receive_data_register;

   // A sample is taken only at the phases the vote looks at.
   function automatic logic sample_point(input rx_state_type st, input logic [3:0] ph);
      sample_point = (ph == PH_RT8) || (ph == PH_RT9) ||
         ((st == RX_START) && ((ph == PH_RT3) || (ph == PH_RT5)));
   endfunction : sample_point

   wire logic rie = ctrl[CB_RX_IE];
   wire logic dre = ctrl[CB_DMA_RE];
   wire logic standby = ctrl[CB_STANDBY];
   wire logic wake_sel = ctrl[CB_WAKE_SEL];
   wire logic idle_count_start_select = ctrl[CB_IDLE_START];
   wire logic nine_bit = ctrl[CB_NINE_BIT];
   wire logic dma_mode = rie & dre;
   wire logic [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
   wire logic [3:0] idle_thr = nine_bit ? IDLE_BITS_LONG : IDLE_BITS_SHORT;

   // Oversample tick; with the default the block clock already runs at sixteen times the baud rate.
   assign tick = (div_cnt == 16'h0000);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         div_cnt <= 16'h0000;
      else if (tick)
         div_cnt <= 16'(CLKS_PER_TICK - 1);
      else
         div_cnt <= div_cnt - 16'h0001;
   end

   line_sync u_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(serial_input_pin_i),
      .sync_o(rxd)
   );

   majority_vote u_vote
   (
      .samples_i({samp, rxd}),
      .level_o(vote_level),
      .noise_o(vote_noise)
   );

   wire logic at_decide = tick && (phase == PH_RT10);
   wire logic frame_done = at_decide && (state == RX_STOP);
   wire logic stop_ok = vote_level;
   wire logic char_noise = frame_noise | vote_noise;
   wire logic parity_bad = ctrl[CB_PARITY_EN] && (par_acc != ctrl[CB_PARITY_ODD]);
   wire logic is_break = (shift == 9'h000) && !stop_ok;
   wire logic addr_wake = frame_done && standby && wake_sel && shift[8];
   wire logic accept = frame_done && (!standby || addr_wake);
   wire logic idle_hit = (next_idle_bits == idle_thr) && (idle_bits != idle_thr);
   wire logic idle_wake = standby && !wake_sel &&
      ((idle_hit) || (prev_wake_sel && (idle_bits == idle_thr)));

   // Frame recovery: hunt for a falling edge after three ones, then sample each bit.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= RX_HUNT;
         hist <= 3'b000;
         phase <= 4'h0;
         samp <= 2'b00;
         bit_idx <= 4'h0;
         shift <= 9'h000;
         par_acc <= 1'b0;
         frame_noise <= 1'b0;
      end
      else if (tick)
      begin
         if (state != RX_HUNT)
            phase <= phase + 4'h1;
         if (sample_point(state, phase))
            samp <= {samp[0], rxd};
         unique case (state)
            RX_HUNT:
            begin
               hist <= {hist[1:0], rxd};
               if (!rxd && (hist == 3'b111))
               begin
                  state <= RX_START;
                  phase <= 4'h1;
                  shift <= 9'h000;
                  par_acc <= 1'b0;
                  frame_noise <= 1'b0;
               end
            end
            RX_START:
            begin
               if (phase == PH_RT7)
               begin
                  if (vote_level)
                  begin
                     state <= RX_HUNT;
                     hist <= 3'b000;
                  end
                  else if (vote_noise)
                     frame_noise <= 1'b1;
               end
               if ((phase >= PH_RT8) && (phase <= PH_RT10) && rxd)
                  frame_noise <= 1'b1;
               if (phase == PH_LAST)
               begin
                  state <= RX_DATA;
                  bit_idx <= 4'h0;
               end
            end
            RX_DATA:
            begin
               if (phase == PH_RT10)
               begin
                  shift <= {vote_level, shift[8:1]};
                  par_acc <= par_acc ^ vote_level;
                  if (vote_noise)
                     frame_noise <= 1'b1;
               end
               if (phase == PH_LAST)
               begin
                  bit_idx <= bit_idx + 4'h1;
                  if (bit_idx == last_bit)
                     state <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               if (phase == PH_RT10)
               begin
                  state <= RX_HUNT;
                  hist <= stop_ok ? 3'b111 : 3'b000;
               end
            end
         endcase
      end
   end

   // Consecutive ones, counted in bit times, toward an idle character.
   always_comb
   begin
      next_idle_tick = idle_tick;
      next_idle_bits = idle_bits;
      if (tick)
      begin
         unique case (state)
            RX_HUNT:
            begin
               if (!rxd)
               begin
                  next_idle_tick = 4'h0;
                  next_idle_bits = 4'h0;
               end
               else if (idle_tick == PH_LAST)
               begin
                  next_idle_tick = 4'h0;
                  if (idle_bits != idle_thr)
                     next_idle_bits = idle_bits + 4'h1;
               end
               else
                  next_idle_tick = idle_tick + 4'h1;
            end
            RX_START:
            begin
               next_idle_tick = 4'h0;
               next_idle_bits = 4'h0;
            end
            default:
            begin
               if (phase == PH_RT10)
               begin
                  if (!vote_level || idle_count_start_select)
                     next_idle_bits = 4'h0;
                  else if (idle_bits != idle_thr)
                     next_idle_bits = idle_bits + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idle_tick <= 4'h0;
         idle_bits <= 4'h0;
      end
      else
      begin
         idle_tick <= next_idle_tick;
         idle_bits <= next_idle_bits;
      end
   end

   // Avalon-MM slave: every access waits exactly one cycle.
   wire logic bus_req = read_i | write_i;
   wire logic bus_go = bus_req && ack;
   wire logic rd_status = bus_go && read_i && (address_i == OFF_STATUS);
   wire logic rd_data = bus_go && read_i && (address_i == OFF_DATA);
   wire logic ctrl_wr = bus_go && write_i && (address_i == OFF_CONTROL);
   assign waitrequest_o = bus_req && !ack;

   wire logic full_clr = (rd_data && (armed || dma_mode)) || dma_read_i;
   wire logic err_clr = rd_data && armed;
   wire logic overrun_now = accept && receive_full_flag && !full_clr;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ack <= 1'b0;
      else
         ack <= bus_req && !ack;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         armed <= 1'b0;
      else if (rd_status)
         armed <= 1'b1;
      else if (rd_data)
         armed <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         readdata_o <= 32'h00000000;
      else if (read_i && !ack)
      begin
         unique case (address_i)
            OFF_CONTROL: readdata_o <= {19'h00000, ctrl};
            OFF_STATUS: readdata_o <= {24'h000000, (state != RX_HUNT), break_seen_flag, parity_error_flag,
               framing_error_flag, noise_flag, overrun_flag, line_quiet_flag, receive_full_flag};
            OFF_DATA: readdata_o <= {23'h000000, receive_data_register};
            default: readdata_o <= 32'h00000000;
         endcase
      end
   end

   // Software wins over a same-cycle wake-up clear of the standby bit.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl <= CONTROL_RESET;
      else
      begin
         if (addr_wake || idle_wake)
            ctrl[CB_STANDBY] <= 1'b0;
         if (ctrl_wr && byteenable_i[0])
            ctrl[7:0] <= writedata_i[7:0];
         if (ctrl_wr && byteenable_i[1])
            ctrl[12:8] <= writedata_i[12:8];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         prev_wake_sel <= 1'b0;
      else
         prev_wake_sel <= wake_sel;
   end

   // An overrun leaves the older character in place.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         receive_data_register <= 9'h000;
      else if (accept && !overrun_now)
         receive_data_register <= nine_bit ? shift : {1'b0, shift[8:1]};
   end

   // Flags: a setting event always beats a clear in the same cycle.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         receive_full_flag <= 1'b0;
         line_quiet_flag <= 1'b0;
         overrun_flag <= 1'b0;
         noise_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         break_seen_flag <= 1'b0;
      end
      else
      begin
         receive_full_flag <= accept | (receive_full_flag & !full_clr);
         line_quiet_flag <= (idle_hit && !standby) | (line_quiet_flag & !err_clr);
         overrun_flag <= overrun_now | (overrun_flag & !err_clr);
         noise_flag <= (accept && char_noise) | (noise_flag & !err_clr);
         framing_error_flag <= (accept && !stop_ok) | (framing_error_flag & !err_clr);
         parity_error_flag <= (accept && parity_bad) | (parity_error_flag & !err_clr);
         break_seen_flag <= (accept && is_break) | (break_seen_flag & !err_clr);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         char_done_o <= 1'b0;
      else
         char_done_o <= accept;
   end

   assign dma_data_o = receive_data_register;

   // Request gating; standby silences the receiver's requests of every kind.
   assign dma_req_o = !standby && dma_mode && receive_full_flag;
   assign rx_irq_o = !standby && !dre && ((rie && receive_full_flag) ||
      (ctrl[CB_QUIET_IE] && line_quiet_flag));
   assign err_irq_o = !standby && ((ctrl[CB_OVERRUN_IE] && overrun_flag) || (ctrl[CB_NOISE_IE] && noise_flag) ||
      (ctrl[CB_FRAMING_IE] && framing_error_flag) || (ctrl[CB_PARITY_IE] && parity_error_flag));

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_frame_sets_full: assert property (accept |=> receive_full_flag)
      else $error("accepted character did not set receive full");
   a_framing_with_full: assert property ($rose(framing_error_flag) |-> receive_full_flag)
      else $error("framing flag rose without receive full");
   a_overrun_keeps_byte: assert property (overrun_now |=> overrun_flag && $stable(receive_data_register))
      else $error("overrun changed data or missed flag");
   a_dma_clear_only: assert property (dma_read_i && !accept && !rd_data |=> !receive_full_flag
      && $stable(noise_flag) && $stable(framing_error_flag) && $stable(overrun_flag))
      else $error("dma read disturbed error flags");
   a_standby_silent: assert property (standby |-> !rx_irq_o && !err_irq_o && !dma_req_o)
      else $error("request raised in standby");
   a_dma_no_cpu: assert property (dma_mode |-> !rx_irq_o)
      else $error("cpu receive request in dma mode");
   a_start_reject: assert property (tick && state == RX_START && phase == PH_RT7 && vote_level
      |=> state == RX_HUNT)
      else $error("failed start verification not rejected");
   a_data_noise: assert property (at_decide && state == RX_DATA && vote_noise |=> frame_noise)
      else $error("data bit noise not recorded");
   a_stop_framing: assert property (frame_done && !standby && !stop_ok |=> framing_error_flag)
      else $error("bad stop bit not flagged");
   a_idle_wake: assert property (idle_hit && standby && !wake_sel && !ctrl_wr
      |=> !standby && !$rose(line_quiet_flag))
      else $error("idle wake-up misbehaved");
   a_bus_answer: assert property (waitrequest_o |=> !waitrequest_o)
      else $error("slave waited more than one cycle");

   c_char_taken: cover property (accept ##[1:400] rd_data);
   c_overrun: cover property (overrun_now);
   c_addr_wake: cover property (addr_wake);
   c_idle_wake: cover property (idle_wake);

endmodule : async_serial_receiver_recovery

// ===== pkg/receiver_recovery_pkg.sv
// Shared constants and types for the serial receive recovery block.
package receiver_recovery_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [3:0] OFF_CONTROL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_DATA = 4'h8;
   localparam logic [12:0] CONTROL_RESET = 13'h0000;

   // Control register bit positions.
   localparam int CB_RX_IE = 0;
   localparam int CB_DMA_RE = 1;
   localparam int CB_QUIET_IE = 2;
   localparam int CB_OVERRUN_IE = 3;
   localparam int CB_NOISE_IE = 4;
   localparam int CB_FRAMING_IE = 5;
   localparam int CB_PARITY_IE = 6;
   localparam int CB_STANDBY = 7;
   localparam int CB_WAKE_SEL = 8;
   localparam int CB_IDLE_START = 9;
   localparam int CB_PARITY_EN = 10;
   localparam int CB_PARITY_ODD = 11;
   localparam int CB_NINE_BIT = 12;

   // Status register bit positions.
   localparam int SB_FULL = 0;
   localparam int SB_QUIET = 1;
   localparam int SB_OVERRUN = 2;
   localparam int SB_NOISE = 3;
   localparam int SB_FRAMING = 4;
   localparam int SB_PARITY = 5;
   localparam int SB_BREAK = 6;
   localparam int SB_PROGRESS = 7;

   // Oversample tick phases, counted from zero at the first tick of a bit.
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] PH_RT3 = 4'h2;
   localparam logic [3:0] PH_RT5 = 4'h4;
   localparam logic [3:0] PH_RT7 = 4'h6;
   localparam logic [3:0] PH_RT8 = 4'h7;
   localparam logic [3:0] PH_RT9 = 4'h8;
   localparam logic [3:0] PH_RT10 = 4'h9;
   localparam logic [3:0] PH_LAST = 4'(OVERSAMPLE - 1);

   // Idle character length in bit times for 8-bit and 9-bit characters.
   localparam logic [3:0] IDLE_BITS_SHORT = 4'ha;
   localparam logic [3:0] IDLE_BITS_LONG = 4'hb;

   typedef enum logic [1:0] {
      RX_HUNT = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_type;

endpackage : receiver_recovery_pkg

// ===== logic/line_sync.sv
// Two-stage synchroniser for the serial input line.
`timescale 1ns/1ps
module line_sync
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic stage_one;

   // The line idles high, so both stages reset to one to avoid a false start edge.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage_one <= 1'b1;
         sync_o <= 1'b1;
      end
      else
      begin
         stage_one <= async_i;
         sync_o <= stage_one;
      end
   end

endmodule : line_sync

// ===== logic/majority_vote.sv
// Three-sample majority vote with noise indication.
`timescale 1ns/1ps
module majority_vote
(
   input wire logic [2:0] samples_i,
   output logic level_o,
   output logic noise_o
);
   always_comb
   begin
      level_o = (samples_i[0] & samples_i[1]) | (samples_i[0] & samples_i[2]) | (samples_i[1] & samples_i[2]);
      noise_o = (samples_i != 3'b000) && (samples_i != 3'b111);
   end

endmodule : majority_vote

// ===== tb/serial_tx_model.sv
// Behavioural remote transmitter that drives the serial receive line.
`timescale 1ns/1ps
module serial_tx_model
(
   input wire logic clk_i,
   output logic line_o
);
   initial line_o = 1'b1;

   // Holds the line at one level for a number of ticks.
   task automatic hold(input logic level, input int ticks);
      repeat (ticks)
      begin
         @(posedge clk_i);
         line_o <= level;
      end
   endtask : hold

   // Start bit, eight bits least significant first, then the stop level.
   // The glitch inverts only the mid-bit tick, so one vote in three disagrees and the bit value survives.
   task automatic send(input logic [7:0] data, input logic stop, input int glitch_bit);
      logic [9:0] bits;
      bits = {stop, data, 1'b0};
      for (int b = 0; b < 10; b++)
      begin
         for (int t = 0; t < 16; t++)
         begin
            @(posedge clk_i);
            line_o <= bits[b] ^ (b == glitch_bit && t == 8);
         end
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask : send
endmodule : serial_tx_model

// ===== tb/async_serial_receiver_recovery_tb.sv
// Self-checking bench for the serial receive recovery block.
`timescale 1ns/1ps
module async_serial_receiver_recovery_tb;
   import receiver_recovery_pkg::*;

   typedef struct {logic [7:0] d; logic stop; int g; logic [7:0] st;} row_type;

   logic clk_i;
   logic rst_i = 1'b1;
   logic [3:0] address_i = 4'h0;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [3:0] byteenable_i = 4'hf;
   logic dma_read_i = 1'b0;
   logic [31:0] readdata_o;
   logic [8:0] dma_data_o;
   logic waitrequest_o, char_done_o, rx_irq_o, err_irq_o, dma_req_o, line;
   logic [31:0] rd;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   row_type rows [6] = '{'{8'ha5, 1'b1, -1, 8'h01}, '{8'h3c, 1'b0, -1, 8'h11}, '{8'h00, 1'b0, -1, 8'h51},
      '{8'h5a, 1'b1, 3, 8'h09}, '{8'hc3, 1'b1, 0, 8'h09}, '{8'h96, 1'b1, 9, 8'h09}};

   async_serial_receiver_recovery #(.CLKS_PER_TICK(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .serial_input_pin_i(line), .dma_read_i(dma_read_i),
      .dma_data_o(dma_data_o), .char_done_o(char_done_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o),
      .dma_req_o(dma_req_o));

   serial_tx_model tx (.clk_i(clk_i), .line_o(line));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // The request stands until a rising edge sees waitrequest low; data is taken at that edge.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= wd;
      write_i <= wr;
      read_i <= ~wr;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (waitrequest_o !== 1'b0 && n < 100);
      rd = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      @(negedge clk_i);
      check("bus_wait", n < 100, 1'b1);
   endtask : bus

   // Sends one character and watches the whole frame, so a strobe that must not come is caught too.
   task automatic frame(input logic [7:0] d, input logic stop, input int g, input logic want);
      logic seen;
      seen = 1'b0;
      fork
         tx.send(d, stop, g);
         repeat (180)
         begin
            @(negedge clk_i);
            if (char_done_o === 1'b1)
               seen = 1'b1;
         end
      join
      check("char_done", seen, want);
   endtask : frame

   // Status read arms the clear, the following data read clears every flag.
   task automatic clear_flags();
      bus(1'b0, OFF_STATUS, 32'h0);
      bus(1'b0, OFF_DATA, 32'h0);
   endtask : clear_flags

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         error_cnt++;
         summarize();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFF_CONTROL, 32'h0);
      check("control_reset", rd, 32'(CONTROL_RESET));
      bus(1'b0, OFF_STATUS, 32'h0);
      check("status_reset", rd, 32'h0);
      bus(1'b0, 4'hc, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h31);
      foreach (rows[i])
      begin
         frame(rows[i].d, rows[i].stop, rows[i].g, 1'b1);
         check("rx_irq", rx_irq_o, 1'b1);
         check("err_irq", err_irq_o, |(rows[i].st & 8'h18));
         bus(1'b0, OFF_STATUS, 32'h0);
         check("status", rd & 32'h7d, rows[i].st);
         bus(1'b0, OFF_DATA, 32'h0);
         check("data", rd, rows[i].d);
      end
      // A two-tick dip fails start verification and must leave no character.
      tx.hold(1'b0, 2);
      tx.hold(1'b1, 200);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("rehunt", rd & 32'h01, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h440);
      frame(8'h01, 1'b1, -1, 1'b1);
      check("parity_irq", err_irq_o, 1'b1);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("parity", rd & 32'h7d, 32'h21);
      bus(1'b0, OFF_DATA, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h08);
      frame(8'h11, 1'b1, -1, 1'b1);
      frame(8'h22, 1'b1, -1, 1'b1);
      check("overrun_irq", err_irq_o, 1'b1);
      bus(1'b0, OFF_DATA, 32'h0);
      check("overrun_data", rd, 32'h11);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("overrun", rd & 32'h7d, 32'h05);
      bus(1'b0, OFF_DATA, 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("cleared", rd & 32'h7d, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h23);
      frame(8'h33, 1'b0, -1, 1'b1);
      check("dma_req", dma_req_o, 1'b1);
      check("dma_cpu_irq", rx_irq_o, 1'b0);
      check("dma_err_irq", err_irq_o, 1'b1);
      check("dma_data", dma_data_o, 32'h33);
      @(posedge clk_i);
      dma_read_i <= 1'b1;
      @(posedge clk_i);
      dma_read_i <= 1'b0;
      @(negedge clk_i);
      check("dma_req_done", dma_req_o, 1'b0);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("dma_keep", rd & 32'h7d, 32'h10);
      bus(1'b1, OFF_CONTROL, 32'h22);
      bus(1'b0, OFF_DATA, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h23);
      check("err_cleared", err_irq_o, 1'b0);
      frame(8'h44, 1'b1, -1, 1'b1);
      bus(1'b0, OFF_DATA, 32'h0);
      check("dma_cpu_data", rd, 32'h44);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("dma_read_clear", rd & 32'h7d, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h04);
      frame(8'h55, 1'b1, -1, 1'b1);
      clear_flags();
      tx.hold(1'b1, 250);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("quiet", rd & 32'h02, 32'h02);
      check("quiet_irq", rx_irq_o, 1'b1);
      bus(1'b1, OFF_CONTROL, 32'h01);
      frame(8'h66, 1'b1, -1, 1'b1);
      bus(1'b1, OFF_CONTROL, 32'h181);
      check("standby_irq", rx_irq_o, 1'b0);
      clear_flags();
      frame(8'h12, 1'b1, -1, 1'b0);
      tx.hold(1'b1, 20);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("standby_drop", rd & 32'h01, 32'h0);
      frame(8'h80, 1'b1, -1, 1'b1);
      bus(1'b0, OFF_CONTROL, 32'h0);
      check("mark_wake", rd, 32'h101);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("mark_full", rd & 32'h01, 32'h01);
      bus(1'b0, OFF_DATA, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h80);
      frame(8'h12, 1'b1, -1, 1'b0);
      tx.hold(1'b1, 250);
      bus(1'b0, OFF_CONTROL, 32'h0);
      check("idle_wake", rd, 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("idle_no_flags", rd & 32'h03, 32'h0);
      bus(1'b1, OFF_CONTROL, 32'h180);
      bus(1'b1, OFF_CONTROL, 32'h80);
      tx.hold(1'b1, 3);
      bus(1'b0, OFF_CONTROL, 32'h0);
      check("select_wake", rd, 32'h0);
      // Counting from after the stop bit, a run of ones inside the character must not end the idle count early.
      bus(1'b1, OFF_CONTROL, 32'h200);
      frame(8'hff, 1'b1, -1, 1'b1);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("idle_after_stop", rd & 32'h03, 32'h01);
      bus(1'b0, OFF_DATA, 32'h0);
      check("ones_data", rd, 32'hff);
      // Nine-bit character with odd parity; the line high after the frame serves as its stop bit.
      bus(1'b1, OFF_CONTROL, 32'h1c00);
      frame(8'h00, 1'b1, -1, 1'b1);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("odd_parity_ok", rd & 32'h7d, 32'h01);
      bus(1'b0, OFF_DATA, 32'h0);
      check("ninth_bit", rd, 32'h100);
      summarize();
   end
endmodule : async_serial_receiver_recovery_tb
